//--- core/tcgcc_input_edge.sv
`timescale 1ns/1ns
`default_nettype none
module tcgcc_input_edge (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic mck_tick,
  input wire logic filter_en,
  input wire logic pin,
  output logic edge_pulse
);
  logic samp1_reg;
  logic samp2_reg;
  logic level_reg;
  logic level_next;

  // ----------------------------------------
  // Sampling and filter
  // ----------------------------------------
  always_comb begin
    if (!filter_en) begin
      level_next = pin;
    end else if (samp1_reg == samp2_reg) begin
      level_next = samp2_reg;
    end else begin
      level_next = level_reg;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      samp1_reg <= 1'b0;
      samp2_reg <= 1'b0;
      level_reg <= 1'b0;
    end else if (mck_tick) begin
      samp1_reg <= pin;
      samp2_reg <= samp1_reg;
      level_reg <= level_next;
    end
  end

  // ----------------------------------------
  // Rising edge pulse
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      edge_pulse <= 1'b0;
    end else begin
      edge_pulse <= mck_tick & level_next & ~level_reg;
    end
  end
endmodule // tcgcc_input_edge
`default_nettype wire

//--- core/tcgcc_pkg.sv
// Function
// - Master forwards interrupt, start trigger and count clock to its slaves only.
// - A master never takes interrupt, trigger or clock from another master.
// - Split into two 8-bit halves only on channels 1 and 3, by split bit.
// - Split upper half runs as interval timer and interrupts at its start.
// - Split upper half clock comes from the operating clock select bit.
// - Upper half has own start, stop and enable status; lower uses normal ones.
// - In 16-bit operation upper start and stop writes do nothing.
// - Source select 0 picks prescaled clock, 1 picks input pin edges.
// - Prescaled clock spans system clock to system clock over 2 to the 15.
// - Edge mode samples input on operating clock, pulses on rising edge.
// - Edge mode start waits for a valid input edge before counting.
// - Noise filter needs two equal consecutive samples before a change counts.
package tcgcc_pkg;
  localparam int NUM_CHAN = 4;
  localparam int PRESC_MAX_SHIFT = 15;
  localparam logic [7:0] ADDR_START = 8'h00;
  localparam logic [7:0] ADDR_STOP = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_PRESC = 8'h0c;
  localparam logic [7:0] ADDR_FILTER = 8'h10;
  localparam logic [7:0] ADDR_MODE0 = 8'h20;
  localparam logic [7:0] ADDR_MODE_LAST = 8'h2c;
  localparam int CH_LSB = 0;
  localparam int UP1_BIT = 4;
  localparam int UP3_BIT = 5;
  localparam int MODE_MD_BIT = 0;
  localparam int MODE_SLAVE_BIT = 10;
  localparam int MODE_MASTER_SPLIT_BIT = 11;
  localparam int MODE_CCS_BIT = 12;
  localparam int MODE_CKS_BIT = 15;
  localparam int PRESC_SEL0_LSB = 0;
  localparam int PRESC_SEL1_LSB = 4;
  localparam logic [15:0] MODE_RESET = 16'h0000;
  localparam logic [7:0] PRESC_RESET = 8'h00;
  localparam logic [3:0] FILTER_RESET = 4'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

//--- core/tcgcc_top.sv
// Our own choices: the address map and the AXI4-Lite register port.
`timescale 1ns/1ns
`default_nettype none
module tcgcc_top #(
  parameter int PRESC_SHIFT_MAX = tcgcc_pkg::PRESC_MAX_SHIFT
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [3:0] timer_input_pin,
  output logic [3:0] count_clock,
  output logic [3:0] chan_start_detect,
  output logic [3:0] chan_interrupt_request,
  output logic [3:0] group_interrupt_source,
  output logic [1:0] upper_count_clock,
  output logic chan1_upper_interrupt,
  output logic chan3_upper_interrupt
);
  localparam int NCH = tcgcc_pkg::NUM_CHAN;

  if (PRESC_SHIFT_MAX < 1 || PRESC_SHIFT_MAX > tcgcc_pkg::PRESC_MAX_SHIFT) begin : g_bad_shift
    $error("PRESC_SHIFT_MAX out of range");
  end

  // ----------------------------------------
  // Functions
  // ----------------------------------------
  // Prescaled enable: select 0 stays high, k divides by 2**k
  function automatic logic presc_tick(input logic [14:0] cnt, input logic [3:0] sel);
    logic [14:0] mask;
    mask = 15'h7fff >> (4'hf - sel);
    if (sel == 4'h0 || sel > 4'(PRESC_SHIFT_MAX)) begin
      return 1'b1;
    end
    return (cnt & mask) == mask;
  endfunction

  // Master of a slave: nearest lower master, no master skipped
  function automatic logic [2:0] master_of(input int n, input logic [3:0] is_m);
    logic [2:0] res;
    res = 3'h0;
    if (n == 1 && is_m[0]) begin
      res = 3'h4;
    end else if (n == 2 && is_m[0]) begin
      res = 3'h4;
    end else if (n == 3 && is_m[2]) begin
      res = 3'h6;
    end else if (n == 3 && is_m[0]) begin
      res = 3'h4;
    end
    return res;
  endfunction

  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  logic rst_meta_reg;
  logic rst_n;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta_reg <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n <= rst_meta_reg;
    end
  end

  // ----------------------------------------
  // Registers and bus
  // ----------------------------------------
  logic [15:0] mode_reg [NCH];
  logic [7:0] presc_reg;
  logic [3:0] filter_reg;
  logic [3:0] en_reg;
  logic [1:0] up_en_reg;
  logic [7:0] aw_addr_reg;
  logic aw_held_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic w_held_reg;
  logic wr_fire;
  logic wr_hit;
  logic [5:0] start_wr;
  logic [5:0] stop_wr;
  logic [31:0] rd_value;
  logic rd_hit;

  assign wr_fire = aw_held_reg & w_held_reg & ~s_axi_bvalid;
  assign wr_hit = aw_addr_reg == tcgcc_pkg::ADDR_START || aw_addr_reg == tcgcc_pkg::ADDR_STOP
    || aw_addr_reg == tcgcc_pkg::ADDR_PRESC || aw_addr_reg == tcgcc_pkg::ADDR_FILTER
    || (aw_addr_reg >= tcgcc_pkg::ADDR_MODE0 && aw_addr_reg <= tcgcc_pkg::ADDR_MODE_LAST
    && aw_addr_reg[1:0] == 2'h0);
  assign start_wr = (wr_fire && aw_addr_reg == tcgcc_pkg::ADDR_START && w_strb_reg[0])
    ? w_data_reg[5:0] : 6'h00;
  assign stop_wr = (wr_fire && aw_addr_reg == tcgcc_pkg::ADDR_STOP && w_strb_reg[0])
    ? w_data_reg[5:0] : 6'h00;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 32'h00000000;
      w_strb_reg <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= tcgcc_pkg::RESP_OKAY;
    end else begin
      s_axi_awready <= ~aw_held_reg & ~s_axi_awready & s_axi_awvalid;
      s_axi_wready <= ~w_held_reg & ~s_axi_wready & s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? tcgcc_pkg::RESP_OKAY : tcgcc_pkg::RESP_SLVERR;
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int n = 0; n < NCH; n++) begin
        mode_reg[n] <= tcgcc_pkg::MODE_RESET;
      end
      presc_reg <= tcgcc_pkg::PRESC_RESET;
      filter_reg <= tcgcc_pkg::FILTER_RESET;
    end else if (wr_fire) begin
      if (aw_addr_reg == tcgcc_pkg::ADDR_PRESC && w_strb_reg[0]) begin
        presc_reg <= w_data_reg[7:0];
      end
      if (aw_addr_reg == tcgcc_pkg::ADDR_FILTER && w_strb_reg[0]) begin
        filter_reg <= w_data_reg[3:0];
      end
      for (int n = 0; n < NCH; n++) begin
        if (aw_addr_reg == tcgcc_pkg::ADDR_MODE0 + 8'(4 * n)) begin
          if (w_strb_reg[0]) begin
            mode_reg[n][7:0] <= w_data_reg[7:0];
          end
          if (w_strb_reg[1]) begin
            mode_reg[n][15:8] <= w_data_reg[15:8];
          end
        end
      end
    end
  end

  always_comb begin
    rd_value = 32'h00000000;
    rd_hit = 1'b1;
    if (s_axi_araddr == tcgcc_pkg::ADDR_START || s_axi_araddr == tcgcc_pkg::ADDR_STOP) begin
      rd_value = 32'h00000000;
    end else if (s_axi_araddr == tcgcc_pkg::ADDR_STATUS) begin
      rd_value = {26'h0000000, up_en_reg, en_reg};
    end else if (s_axi_araddr == tcgcc_pkg::ADDR_PRESC) begin
      rd_value = {24'h000000, presc_reg};
    end else if (s_axi_araddr == tcgcc_pkg::ADDR_FILTER) begin
      rd_value = {28'h0000000, filter_reg};
    end else if (s_axi_araddr >= tcgcc_pkg::ADDR_MODE0 && s_axi_araddr <= tcgcc_pkg::ADDR_MODE_LAST
      && s_axi_araddr[1:0] == 2'h0) begin
      rd_value = {16'h0000, mode_reg[s_axi_araddr[3:2]]};
    end else begin
      rd_hit = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= tcgcc_pkg::RESP_OKAY;
    end else begin
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_value;
        s_axi_rresp <= rd_hit ? tcgcc_pkg::RESP_OKAY : tcgcc_pkg::RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Prescaler and operating clocks
  // ----------------------------------------
  logic [14:0] presc_cnt_reg;
  logic [1:0] mck_tick;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      presc_cnt_reg <= 15'h0000;
    end else begin
      presc_cnt_reg <= presc_cnt_reg + 15'h0001;
    end
  end

  assign mck_tick[0] = presc_tick(presc_cnt_reg, presc_reg[tcgcc_pkg::PRESC_SEL0_LSB +: 4]);
  assign mck_tick[1] = presc_tick(presc_cnt_reg, presc_reg[tcgcc_pkg::PRESC_SEL1_LSB +: 4]);

  // ----------------------------------------
  // Grouping decode and clock selection
  // ----------------------------------------
  logic [3:0] is_master;
  logic [3:0] is_slave;
  logic [3:0] is_split;
  logic [1:0] master_idx [NCH];
  logic [3:0] own_mck;
  logic [3:0] input_edge;
  logic [3:0] own_clk;
  logic [3:0] grp_clk;
  logic [3:0] start_eff;
  logic [3:0] stop_eff;
  logic [1:0] up_clk;

  always_comb begin
    for (int n = 0; n < NCH; n++) begin
      logic [2:0] m;
      m = master_of(n, is_master);
      is_master[n] = mode_reg[n][tcgcc_pkg::MODE_MASTER_SPLIT_BIT] && (n % 2 == 0);
      is_split[n] = mode_reg[n][tcgcc_pkg::MODE_MASTER_SPLIT_BIT] && (n % 2 == 1);
      is_slave[n] = mode_reg[n][tcgcc_pkg::MODE_SLAVE_BIT] && n != 0 && !is_master[n] && m[2];
      master_idx[n] = m[1:0];
      own_mck[n] = mck_tick[mode_reg[n][tcgcc_pkg::MODE_CKS_BIT]];
      own_clk[n] = mode_reg[n][tcgcc_pkg::MODE_CCS_BIT] ? input_edge[n] : own_mck[n];
    end
    for (int n = 0; n < NCH; n++) begin
      grp_clk[n] = is_slave[n] ? own_clk[master_idx[n]] : own_clk[n];
      start_eff[n] = start_wr[n] | (is_slave[n] & start_wr[master_idx[n]]);
      stop_eff[n] = stop_wr[n] | (is_slave[n] & stop_wr[master_idx[n]]);
    end
    up_clk[0] = mck_tick[mode_reg[1][tcgcc_pkg::MODE_CKS_BIT]];
    up_clk[1] = mck_tick[mode_reg[3][tcgcc_pkg::MODE_CKS_BIT]];
  end

  for (genvar g = 0; g < NCH; g++) begin : g_edge
    tcgcc_input_edge u_edge (
      .clk(clk),
      .rst_n(rst_n),
      .mck_tick(own_mck[g]),
      .filter_en(filter_reg[g]),
      .pin(timer_input_pin[g]),
      .edge_pulse(input_edge[g])
    );
  end

  // ----------------------------------------
  // Lower or 16-bit channel control
  // ----------------------------------------
  logic [3:0] pend_reg;
  logic [3:0] irq_now;

  assign irq_now = pend_reg & en_reg & grp_clk
    & {mode_reg[3][0], mode_reg[2][0], mode_reg[1][0], mode_reg[0][0]};

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      en_reg <= 4'h0;
      pend_reg <= 4'h0;
      count_clock <= 4'h0;
      chan_start_detect <= 4'h0;
      chan_interrupt_request <= 4'h0;
      group_interrupt_source <= 4'h0;
    end else begin
      for (int n = 0; n < NCH; n++) begin
        if (stop_eff[n]) begin
          en_reg[n] <= 1'b0;
          pend_reg[n] <= 1'b0;
        end else if (start_eff[n]) begin
          en_reg[n] <= 1'b1;
          pend_reg[n] <= 1'b1;
        end else if (en_reg[n] && grp_clk[n]) begin
          pend_reg[n] <= 1'b0;
        end
        count_clock[n] <= en_reg[n] & grp_clk[n];
        chan_start_detect[n] <= pend_reg[n] & en_reg[n] & grp_clk[n];
        chan_interrupt_request[n] <= irq_now[n];
        group_interrupt_source[n] <= is_slave[n] & irq_now[master_idx[n]];
      end
    end
  end

  // ----------------------------------------
  // Upper half of channels 1 and 3
  // ----------------------------------------
  logic [1:0] up_pend_reg;
  logic [1:0] split_pair;

  assign split_pair = {is_split[3], is_split[1]};

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      up_en_reg <= 2'h0;
      up_pend_reg <= 2'h0;
      upper_count_clock <= 2'h0;
      chan1_upper_interrupt <= 1'b0;
      chan3_upper_interrupt <= 1'b0;
    end else begin
      for (int k = 0; k < 2; k++) begin
        if (!split_pair[k]) begin
          up_pend_reg[k] <= 1'b0;
        end else if (stop_wr[tcgcc_pkg::UP1_BIT + k]) begin
          up_en_reg[k] <= 1'b0;
          up_pend_reg[k] <= 1'b0;
        end else if (start_wr[tcgcc_pkg::UP1_BIT + k]) begin
          up_en_reg[k] <= 1'b1;
          up_pend_reg[k] <= 1'b1;
        end else if (up_en_reg[k] && up_clk[k]) begin
          up_pend_reg[k] <= 1'b0;
        end
        upper_count_clock[k] <= split_pair[k] & up_en_reg[k] & up_clk[k];
      end
      chan1_upper_interrupt <= split_pair[0] & up_pend_reg[0] & up_en_reg[0] & up_clk[0];
      chan3_upper_interrupt <= split_pair[1] & up_pend_reg[1] & up_en_reg[1] & up_clk[1];
    end
  end
endmodule // tcgcc_top
`default_nettype wire

//--- verif/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  // ----------------------------------------
  // Design and stimulus
  // ----------------------------------------
  typedef struct packed {logic we; logic [7:0] a; logic [31:0] d; logic [31:0] x; logic [1:0] r;} tcgcc_row_t;
  localparam logic [1:0] OK = tcgcc_pkg::RESP_OKAY;
  localparam logic [7:0] A_ST = tcgcc_pkg::ADDR_START;
  localparam logic [7:0] A_SP = tcgcc_pkg::ADDR_STOP;
  localparam logic [7:0] A_SS = tcgcc_pkg::ADDR_STATUS;
  localparam logic [7:0] A_PR = tcgcc_pkg::ADDR_PRESC;
  localparam logic [7:0] A_FI = tcgcc_pkg::ADDR_FILTER;
  localparam logic [7:0] A_M0 = tcgcc_pkg::ADDR_MODE0;
  localparam logic [7:0] A_ML = tcgcc_pkg::ADDR_MODE_LAST;
  logic clk = 1'h0, resetn = 1'h0, awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, v;
  logic awready, wready, bvalid, arready, rvalid, up1, up3;
  logic [1:0] bresp, rresp, ucc, r;
  logic [3:0] pins, cclk, sdet, irq, grp;
  logic [3:0] level_req = 4'h0;
  logic [3:0] wstrb = 4'hf;
  logic [19:0] obs;
  int error_cnt = 0, check_count = 0, n, n1;
  tcgcc_row_t rows [10] = '{
    '{1'h0, A_SS, 32'h0, 32'h0, OK},
    '{1'h0, A_PR, 32'h0, {24'h0, tcgcc_pkg::PRESC_RESET}, OK},
    '{1'h0, A_FI, 32'h0, {28'h0, tcgcc_pkg::FILTER_RESET}, OK},
    '{1'h0, A_ML, 32'h0, {16'h0, tcgcc_pkg::MODE_RESET}, OK},
    '{1'h1, A_PR, 32'h5a, 32'h5a, OK},
    '{1'h1, A_FI, 32'hf, 32'hf, OK},
    '{1'h1, A_ML, 32'h8c01, 32'h8c01, OK},
    '{1'h1, 8'h40, 32'h1, 32'h0, tcgcc_pkg::RESP_SLVERR},
    '{1'h1, A_PR, 32'h0, 32'h0, OK},
    '{1'h1, A_ML, 32'h0, 32'h0, OK}};
  assign obs = {up3, up1, ucc, grp, irq, sdet, cclk};
  always #5 clk = ~clk;
  tcgcc_pin_model u_pins (.level_req(level_req), .timer_input_pin(pins));
  tcgcc_top uut (
    .clk(clk), .resetn(resetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .timer_input_pin(pins), .count_clock(cclk),
    .chan_start_detect(sdet), .chan_interrupt_request(irq), .group_interrupt_source(grp),
    .upper_count_clock(ucc), .chan1_upper_interrupt(up1), .chan3_upper_interrupt(up3));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] rs);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end while (bvalid !== 1'h1);
    rs = bresp;
    bready <= 1'h0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'h0;
    end while (rvalid !== 1'h1);
    d = rdata;
    rs = rresp;
    rready <= 1'h0;
    @(posedge clk);
  endtask
  task automatic wok(input logic [7:0] a, input logic [31:0] d);
    wr(a, d, r);
    check(r, OK);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] x);
    rd(a, v, r);
    check(v, x);
  endtask
  task automatic wait_obs(input int b, output int cnt);
    cnt = 0;
    while (obs[b] !== 1'h1 && cnt < 300) begin
      @(posedge clk);
      cnt++;
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    #200000;
    error_cnt++;
    print_verdict();
  end
  initial begin
    repeat (12) @(posedge clk);
    resetn <= 1'h1;
    repeat (3) @(posedge clk);
    check(obs, 20'h0);
    foreach (rows[i]) begin
      if (rows[i].we) begin
        wr(rows[i].a, rows[i].d, r);
        check(r, rows[i].r);
      end
      rd(rows[i].a, v, r);
      check(v, rows[i].x);
      check(r, rows[i].r);
    end
    wstrb <= 4'h1;
    wok(A_ML, 32'h8c01);
    rchk(A_ML, 32'h1);
    wstrb <= 4'hf;
    wok(A_ML, 32'h0);
    $display("test registers done");
    wok(A_M0, 32'h1);
    wok(A_ST, 32'h1);
    wait_obs(4, n);
    check(irq[0], 1'h1);
    check(cclk[0], 1'h1);
    @(posedge clk);
    check(sdet[0], 1'h0);
    check(cclk[0], 1'h1);
    rchk(A_SS, 32'h1);
    wok(A_SP, 32'h1);
    rchk(A_SS, 32'h0);
    check(cclk[0], 1'h0);
    $display("test start stop done");
    wok(A_M0, 32'h0801);
    wok(A_M0 + 8'h04, 32'h0400);
    wok(A_ST, 32'h3);
    wait_obs(8, n);
    check(n < 300, 1'h1);
    wait_obs(13, n);
    check(n <= 1, 1'h1);
    check(cclk[1], cclk[0]);
    wok(A_SP, 32'h3);
    rchk(A_SS, 32'h0);
    wok(A_M0 + 8'h08, 32'h0800);
    wok(A_M0 + 8'h0c, 32'h0400);
    wok(A_ST, 32'h1);
    rchk(A_SS, 32'h3);
    wok(A_ST, 32'h1);
    rchk(A_SS, 32'h3);
    wok(A_ST, 32'hc);
    rchk(A_SS, 32'hf);
    wok(A_SP, 32'hf);
    rchk(A_SS, 32'h0);
    wok(A_M0, 32'h0);
    wok(A_M0 + 8'h04, 32'h0);
    wok(A_M0 + 8'h08, 32'h0);
    wok(A_M0 + 8'h0c, 32'h0);
    $display("test group done");
    wok(A_PR, 32'h23);
    wok(A_ST, 32'h8);
    wait_obs(3, n);
    @(posedge clk);
    wait_obs(3, n);
    check(n, 7);
    wok(A_SP, 32'h8);
    $display("test prescaler done");
    for (int i = 0; i < 2; i++) begin
      logic [7:0] ma;
      ma = (i == 0) ? A_M0 + 8'h04 : A_M0 + 8'h0c;
      wok(A_ST, 32'h10 << i);
      repeat (4) @(posedge clk);
      check(ucc[i], 1'h0);
      rchk(A_SS, 32'h0);
      wok(ma, 32'h8800);
      wok(A_ST, 32'h10 << i);
      wait_obs(18 + i, n);
      check(n < 300, 1'h1);
      rchk(A_SS, 32'h10 << i);
      wait_obs(16 + i, n);
      @(posedge clk);
      wait_obs(16 + i, n);
      check(n, 3);
      wok(A_SP, 32'h10 << i);
      rchk(A_SS, 32'h0);
      wok(ma, 32'h0);
    end
    $display("test split done");
    wok(A_PR, 32'h0);
    wok(A_M0 + 8'h08, 32'h1000);
    wok(A_ST, 32'h4);
    repeat (10) @(posedge clk);
    check(cclk[2], 1'h0);
    rchk(A_SS, 32'h4);
    for (int f = 0; f < 2; f++) begin
      wok(A_FI, 32'h4 * f);
      level_req[2] <= 1'h1;
      wait_obs(2, n);
      @(posedge clk);
      check(cclk[2], 1'h0);
      if (f == 0) n1 = n;
      level_req[2] <= 1'h0;
      repeat (8) @(posedge clk);
    end
    check(n1 >= 1 && n1 <= 4, 1'h1);
    check(n - n1, 2);
    level_req[2] <= 1'h1;
    @(posedge clk);
    level_req[2] <= 1'h0;
    wait_obs(2, n);
    check(n, 300);
    wok(A_SP, 32'h4);
    $display("test edge input done");
    resetn <= 1'h0;
    repeat (2) @(posedge clk);
    resetn <= 1'h1;
    repeat (3) @(posedge clk);
    check(obs, 20'h0);
    rchk(A_FI, {28'h0, tcgcc_pkg::FILTER_RESET});
    rchk(A_SS, 32'h0);
    $display("test reset done");
    print_verdict();
  end
endmodule // tb_top
`default_nettype wire

//--- verif/tcgcc_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module tcgcc_monitor (
  input wire logic clk,
  input wire logic resetn,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] count_clock,
  input wire logic [3:0] chan_start_detect,
  input wire logic [3:0] chan_interrupt_request,
  input wire logic [3:0] group_interrupt_source,
  input wire logic [1:0] upper_count_clock,
  input wire logic chan1_upper_interrupt,
  input wire logic chan3_upper_interrupt
);
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  logic wr_seen_reg;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wr_seen_reg <= 1'h0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      wr_seen_reg <= 1'h1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  property p_sd_pulse;
    (chan_start_detect & $past(chan_start_detect)) == 4'h0;
  endproperty
  a_sd_pulse: assert property (p_sd_pulse) else $error("start detect longer than one cycle");
  property p_irq_pulse;
    (chan_interrupt_request & $past(chan_interrupt_request)) == 4'h0;
  endproperty
  a_irq_pulse: assert property (p_irq_pulse) else $error("interrupt longer than one cycle");
  property p_irq_cause;
    (chan_interrupt_request & ~chan_start_detect) == 4'h0;
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("interrupt without start detect");
  property p_up1_pulse;
    chan1_upper_interrupt |=> !chan1_upper_interrupt;
  endproperty
  a_up1_pulse: assert property (p_up1_pulse) else $error("upper interrupt 1 too long");
  property p_up3_pulse;
    chan3_upper_interrupt |=> !chan3_upper_interrupt;
  endproperty
  a_up3_pulse: assert property (p_up3_pulse) else $error("upper interrupt 3 too long");
  property p_grp_src;
    group_interrupt_source != 4'h0 |-> |(chan_interrupt_request | $past(chan_interrupt_request));
  endproperty
  a_grp_src: assert property (p_grp_src) else $error("group source without master interrupt");
  property p_grp0;
    !group_interrupt_source[0];
  endproperty
  a_grp0: assert property (p_grp0) else $error("channel 0 took a group source");
  property p_idle;
    !wr_seen_reg |-> count_clock == 4'h0 && upper_count_clock == 2'h0;
  endproperty
  a_idle: assert property (p_idle) else $error("count clock before any start");
  c_irq: cover property (chan_interrupt_request[0]);
  c_grp: cover property (group_interrupt_source[1]);
  c_up: cover property (chan1_upper_interrupt);
endmodule // tcgcc_monitor
bind tcgcc_top tcgcc_monitor u_mon (
  .clk(clk), .resetn(resetn), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .count_clock(count_clock), .chan_start_detect(chan_start_detect),
  .chan_interrupt_request(chan_interrupt_request), .group_interrupt_source(group_interrupt_source),
  .upper_count_clock(upper_count_clock), .chan1_upper_interrupt(chan1_upper_interrupt),
  .chan3_upper_interrupt(chan3_upper_interrupt)
);
`default_nettype wire

//--- verif/tcgcc_pin_model.sv
`timescale 1ns/1ns
`default_nettype none
module tcgcc_pin_model (
  input wire logic [3:0] level_req,
  output logic [3:0] timer_input_pin
);
  // Pins move off the clock edge, as an unrelated source would
  initial timer_input_pin = 4'h0;
  always @(level_req) timer_input_pin <= #3 level_req;
endmodule // tcgcc_pin_model
`default_nettype wire
